// File: logic/lpmc_pkg.sv
// Constants, types and reset values for the low power mode controller
package lpmc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register location and layout
  localparam logic [7:0] PMC_ADDR       = 8'h87;  // power_mode_control SFR address
  localparam int         PMC_IDLE_BIT   = 0;      // idle_request
  localparam int         PMC_STOP_BIT   = 1;      // stop request
  localparam int         PMC_BAUD_BIT   = 7;      // UART baud doubling, kept only
  localparam logic [7:0] PMC_READ_VALUE = 8'h00;  // Write-only register reads as this

  ////////////////////////////////////////////////////////////////////////////
  // Wake sources
  localparam int NUM_EXT_IRQ = 3;  // ext_irq_line_zero .. ext_irq_line_two

  ////////////////////////////////////////////////////////////////////////////
  // Timing: settle time of the high-frequency oscillator after restart
  localparam int CLK_PERIOD_NS  = 20;
  localparam int OSC_SETTLE_NS  = 2000;
  localparam int OSC_SETTLE_CYC = (OSC_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_W       = $clog2(OSC_SETTLE_CYC + 1);
  localparam logic [SETTLE_W-1:0] SETTLE_ZERO = '0;
  localparam logic [SETTLE_W-1:0] SETTLE_ONE  = SETTLE_W'(1);
  localparam logic [SETTLE_W-1:0] SETTLE_LAST = SETTLE_W'(OSC_SETTLE_CYC - 1);

  ////////////////////////////////////////////////////////////////////////////
  // Operating modes
  typedef enum logic [1:0] {
    LPMC_RUN,
    LPMC_IDLE,
    LPMC_STOP,
    LPMC_OSC_START
  } lpmc_mode_type;

  // Controller state
  typedef struct packed {
    lpmc_mode_type         mode;
    logic                  baud_double;
    logic [SETTLE_W-1:0]   settle;
    logic [7:0]            rdata;
    logic                  halt;
    logic                  hf_en;
    logic                  sys_clk_en;
    logic                  lf_en;
    logic                  wdt_en;
    logic                  wake_pulse;
  } lpmc_state_type;

  localparam lpmc_state_type LPMC_STATE_RESET = '{
    mode:        LPMC_RUN,
    baud_double: 1'b0,
    settle:      SETTLE_ZERO,
    rdata:       PMC_READ_VALUE,
    halt:        1'b0,
    hf_en:       1'b1,
    sys_clk_en:  1'b1,
    lf_en:       1'b1,
    wdt_en:      1'b1,
    wake_pulse:  1'b0
  };

  // Wake detector state
  typedef struct packed {
    logic stop_wake;
    logic idle_wake;
  } lpmc_wake_state_type;

  localparam lpmc_wake_state_type LPMC_WAKE_RESET = '{stop_wake: 1'b0, idle_wake: 1'b0};

endpackage

// File: logic/lpmc_wake_if.sv
// Wake indications passed from the wake detector to the mode controller
`timescale 1ns/1ps
interface lpmc_wake_if;
  logic stop_wake;
  logic idle_wake;

  modport src  (output stop_wake, output idle_wake);
  modport sink (input  stop_wake, input  idle_wake);
endinterface

// File: logic/lpmc_wake_detect.sv
// Registered wake source detector for STOP and IDLE exit
`timescale 1ns/1ps
module lpmc_wake_detect
  import lpmc_pkg::*;
(
  // Clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        sys_rst_i,
  input  wire logic                        ce_i,
  // Wake sources
  input  wire logic [lpmc_pkg::NUM_EXT_IRQ-1:0] ext_irq_i,
  input  wire logic                        lf_timer_irq_i,
  input  wire logic                        ext_reset_req_i,
  input  wire logic                        irq_pending_i,
  // To the controller
  lpmc_wake_if.src                         wake
);

  lpmc_wake_state_type q, d;
  logic [NUM_EXT_IRQ+1:0] stop_src;

  // True when any bit of a source vector is set
  function automatic logic lpmc_any(input logic [NUM_EXT_IRQ+1:0] v);
    logic r;
    r = 1'b0;
    for (int i = 0; i <= NUM_EXT_IRQ + 1; i++) begin
      r = r | v[i];
    end
    return r;
  endfunction

  // Sources able to leave STOP: external lines, low_freq_timer, reset input
  assign stop_src = {ext_reset_req_i, lf_timer_irq_i, ext_irq_i};

  // Next wake indications
  always_comb begin
    d           = q;
    d.stop_wake = lpmc_any(stop_src);
    d.idle_wake = irq_pending_i | lpmc_any(stop_src);
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      q <= LPMC_WAKE_RESET;
    end else if (ce_i) begin
      q <= d;
    end
  end

  assign wake.stop_wake = q.stop_wake;
  assign wake.idle_wake = q.idle_wake;

endmodule

// File: logic/lpmc_top.sv
// Low power mode controller: power_mode_control SFR, IDLE and STOP sequencing
//
// Operation
// - Stop bit write halts fast clock, enters STOP
// - STOP exits only on ext IRQ, timer, reset
// - Idle bit write halts CPU, clocks keep running
// - IDLE exits on any enabled interrupt request
// - Register at 87H is write-only, reads zero
// - In STOP, slow oscillator and watchdog follow configuration
// - Request bits reset to zero, normal mode
// - Low-frequency timer interrupt wakes from STOP
`timescale 1ns/1ps
module lpmc_top
  import lpmc_pkg::*;
(
  // Clock, reset and clock enable
  input  wire logic                             clk_i,
  input  wire logic                             sys_rst_i,
  input  wire logic                             ce_i,
  // SFR access from the CPU core
  input  wire logic                             sfr_wr_i,
  input  wire logic                             sfr_rd_i,
  input  wire logic [7:0]                       sfr_addr_i,
  input  wire logic [7:0]                       sfr_wdata_i,
  output logic      [7:0]                       sfr_rdata_o,
  // Wake sources
  input  wire logic [lpmc_pkg::NUM_EXT_IRQ-1:0] ext_irq_i,
  input  wire logic                             lf_timer_irq_i,
  input  wire logic                             ext_reset_req_i,
  input  wire logic                             irq_pending_i,
  // Oscillator status and STOP configuration
  input  wire logic                             hf_osc_ready_i,
  input  wire logic                             cfg_lf_run_stop_i,
  input  wire logic                             cfg_wdt_run_stop_i,
  // Clock and core control
  output logic                                  cpu_halt_o,
  output logic                                  hf_osc_en_o,
  output logic                                  sys_clk_en_o,
  output logic                                  lf_osc_en_o,
  output logic                                  wdt_en_o,
  output logic                                  baud_double_o,
  output logic                                  wake_pulse_o,
  output lpmc_pkg::lpmc_mode_type               mode_o
);

  lpmc_state_type q, d;
  logic           pmc_wr;
  logic           pmc_rd;
  logic           low_power;

  lpmc_wake_if wake_bus ();

  ////////////////////////////////////////////////////////////////////////////
  // Wake source detector
  lpmc_wake_detect u_wake (
    .clk_i           (clk_i),
    .sys_rst_i       (sys_rst_i),
    .ce_i            (ce_i),
    .ext_irq_i       (ext_irq_i),
    .lf_timer_irq_i  (lf_timer_irq_i),
    .ext_reset_req_i (ext_reset_req_i),
    .irq_pending_i   (irq_pending_i),
    .wake            (wake_bus.src)
  );

  ////////////////////////////////////////////////////////////////////////////
  // SFR decode
  assign pmc_wr = sfr_wr_i && (sfr_addr_i == PMC_ADDR);
  assign pmc_rd = sfr_rd_i && (sfr_addr_i == PMC_ADDR);

  ////////////////////////////////////////////////////////////////////////////
  // Next state and registered outputs
  always_comb begin
    d            = q;
    d.wake_pulse = 1'b0;
    low_power    = 1'b0;
    if (pmc_rd) begin
      d.rdata = PMC_READ_VALUE;
    end
    unique case (q.mode)
      LPMC_RUN: begin
        // Only a running core can write; stop wins over idle
        if (pmc_wr) begin
          d.baud_double = sfr_wdata_i[PMC_BAUD_BIT];
          if (sfr_wdata_i[PMC_STOP_BIT]) begin
            d.mode = LPMC_STOP;
          end else if (sfr_wdata_i[PMC_IDLE_BIT]) begin
            d.mode = LPMC_IDLE;
          end
        end
      end
      LPMC_IDLE: begin
        if (wake_bus.idle_wake) begin
          d.mode       = LPMC_RUN;
          d.wake_pulse = 1'b1;
        end
      end
      LPMC_STOP: begin
        if (wake_bus.stop_wake) begin
          d.mode   = LPMC_OSC_START;
          d.settle = SETTLE_ZERO;
        end
      end
      LPMC_OSC_START: begin
        // Count stable oscillator cycles before releasing the core clock
        if (!hf_osc_ready_i) begin
          d.settle = SETTLE_ZERO;
        end else if (q.settle == SETTLE_LAST) begin
          d.mode       = LPMC_RUN;
          d.wake_pulse = 1'b1;
        end else begin
          d.settle = q.settle + SETTLE_ONE;
        end
      end
    endcase
    // Clock controls follow the mode being entered
    low_power    = (d.mode == LPMC_STOP) || (d.mode == LPMC_OSC_START);
    d.halt       = (d.mode != LPMC_RUN);
    d.hf_en      = (d.mode != LPMC_STOP);
    d.sys_clk_en = (d.mode == LPMC_RUN) || (d.mode == LPMC_IDLE);
    d.lf_en      = low_power ? cfg_lf_run_stop_i : 1'b1;
    d.wdt_en     = low_power ? cfg_wdt_run_stop_i : 1'b1;
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      q <= LPMC_STATE_RESET;
    end else if (ce_i) begin
      q <= d;
    end
  end

  // Outputs straight from the state register
  assign sfr_rdata_o   = q.rdata;
  assign cpu_halt_o    = q.halt;
  assign hf_osc_en_o   = q.hf_en;
  assign sys_clk_en_o  = q.sys_clk_en;
  assign lf_osc_en_o   = q.lf_en;
  assign wdt_en_o      = q.wdt_en;
  assign baud_double_o = q.baud_double;
  assign wake_pulse_o  = q.wake_pulse;
  assign mode_o        = q.mode;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_stop_req;
    ce_i && q.mode == LPMC_RUN && pmc_wr && sfr_wdata_i[PMC_STOP_BIT];
  endsequence

  sequence s_stop_wake;
    ce_i && q.mode == LPMC_STOP && wake_bus.stop_wake;
  endsequence

  sequence s_osc_up_clock_off;
    hf_osc_en_o && !sys_clk_en_o && cpu_halt_o;
  endsequence

  property p_stop_enter;
    s_stop_req |=> mode_o == LPMC_STOP && !hf_osc_en_o && !sys_clk_en_o && cpu_halt_o;
  endproperty
  a_stop_enter: assert property (p_stop_enter) else $error("stop request not taken");

  property p_stop_hold;
    q.mode == LPMC_STOP && !wake_bus.stop_wake |=> mode_o == LPMC_STOP;
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("stop left without wake source");

  property p_idle_enter;
    ce_i && q.mode == LPMC_RUN && pmc_wr && !sfr_wdata_i[PMC_STOP_BIT] && sfr_wdata_i[PMC_IDLE_BIT]
      |=> cpu_halt_o && hf_osc_en_o && sys_clk_en_o && mode_o == LPMC_IDLE;
  endproperty
  a_idle_enter: assert property (p_idle_enter) else $error("idle request not taken");

  property p_idle_wake;
    ce_i && q.mode == LPMC_IDLE && wake_bus.idle_wake
      |=> !cpu_halt_o && wake_pulse_o ##1 (!wake_pulse_o || !$past(ce_i));
  endproperty
  a_idle_wake: assert property (p_idle_wake) else $error("idle not left on interrupt");

  property p_read_zero;
    ce_i && pmc_rd |=> sfr_rdata_o == PMC_READ_VALUE;
  endproperty
  a_read_zero: assert property (p_read_zero) else $error("power register read not zero");

  property p_lf_cfg;
    ce_i && (q.mode == LPMC_STOP) && !wake_bus.stop_wake
      |=> lf_osc_en_o == $past(cfg_lf_run_stop_i) && wdt_en_o == $past(cfg_wdt_run_stop_i);
  endproperty
  a_lf_cfg: assert property (p_lf_cfg) else $error("slow clocks ignore configuration");

  property p_reset_run;
    $past(sys_rst_i) |-> mode_o == LPMC_RUN && !cpu_halt_o && !baud_double_o;
  endproperty
  a_reset_run: assert property (p_reset_run) else $error("reset did not select normal mode");

  property p_wake_restart;
    s_stop_wake |=> s_osc_up_clock_off;
  endproperty
  a_wake_restart: assert property (p_wake_restart) else $error("oscillator not restarted first");

  property p_clk_after_ready;
    $rose(sys_clk_en_o) && $past(q.mode) == LPMC_OSC_START |-> $past(hf_osc_ready_i) && wake_pulse_o;
  endproperty
  a_clk_after_ready: assert property (p_clk_after_ready) else $error("core clock before oscillator ready");

endmodule

// File: tb/lpmc_osc_model.sv
// Behavioural fast oscillator answering the controller's enable
`timescale 1ns/1ps
module lpmc_osc_model #(
  parameter int START_CYC = 5
) (
  // Clock and oscillator enable
  input  wire logic clk_i,
  input  wire logic en_i,
  // Oscillator stable flag
  output logic      ready_o
);
  int cnt = 0;

  ////////////////////////////////////////////////////////////////////////////
  // Start-up count; stability is lost at once when disabled
  always @(posedge clk_i) begin
    if (!en_i) begin
      cnt <= 0;
    end else if (cnt < START_CYC) begin
      cnt <= cnt + 1;
    end
  end

  // Ready only after the full start-up delay
  assign ready_o = en_i && (cnt >= START_CYC);
endmodule

// File: tb/low_power_mode_control_test.sv
// Self-checking bench for the low power mode controller
`timescale 1ns/1ps
module low_power_mode_control_test;
  import lpmc_pkg::*;
  // Oscillator start-up in the partner model, and IDLE wake latency
  localparam int OSC_RAMP_CYC  = 5;
  localparam int IDLE_WAKE_CYC = 2;

  logic          clk_i         = 1'b0;
  logic          sys_rst_i     = 1'b1;
  logic          ce_i          = 1'b1;
  logic          sfr_wr_i      = 1'b0;
  logic          sfr_rd_i      = 1'b0;
  logic [7:0]    sfr_addr_i    = 8'h00;
  logic [7:0]    sfr_wdata_i   = 8'h00;
  logic [4:0]    src           = 5'h00;
  logic          irq_pending_i = 1'b0;
  logic [1:0]    cfg           = 2'h3;
  logic [7:0]    sfr_rdata_o;
  logic          hf_ready;
  logic          cpu_halt_o;
  logic          hf_osc_en_o;
  logic          sys_clk_en_o;
  logic          lf_osc_en_o;
  logic          wdt_en_o;
  logic          baud_double_o;
  logic          wake_pulse_o;
  lpmc_mode_type mode_o;
  int            num_errors    = 0;
  int            tests_run     = 0;

  // Clock
  always #10 clk_i = ~clk_i;

  ////////////////////////////////////////////////////////////////////////////
  // Design and oscillator model
  lpmc_top uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
    .sfr_addr_i(sfr_addr_i), .sfr_wdata_i(sfr_wdata_i), .sfr_rdata_o(sfr_rdata_o), .ext_irq_i(src[2:0]),
    .lf_timer_irq_i(src[3]), .ext_reset_req_i(src[4]), .irq_pending_i(irq_pending_i),
    .hf_osc_ready_i(hf_ready), .cfg_lf_run_stop_i(cfg[1]), .cfg_wdt_run_stop_i(cfg[0]),
    .cpu_halt_o(cpu_halt_o), .hf_osc_en_o(hf_osc_en_o), .sys_clk_en_o(sys_clk_en_o), .lf_osc_en_o(lf_osc_en_o),
    .wdt_en_o(wdt_en_o), .baud_double_o(baud_double_o), .wake_pulse_o(wake_pulse_o), .mode_o(mode_o));
  lpmc_osc_model #(.START_CYC(OSC_RAMP_CYC)) osc (.clk_i(clk_i), .en_i(hf_osc_en_o), .ready_o(hf_ready));

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Status byte: mode, halt, fast osc, system clock, slow osc, watchdog
  function automatic logic [7:0] st(lpmc_mode_type m, logic h, logic f, logic s, logic l, logic w);
    return {1'b0, m, h, f, s, l, w};
  endfunction

  task automatic check_st(input logic [7:0] exp);
    check({1'b0, mode_o, cpu_halt_o, hf_osc_en_o, sys_clk_en_o, lf_osc_en_o, wdt_en_o}, exp);
  endtask

  // One SFR cycle, then four idle slots as software would leave
  task automatic sfr(input logic rd, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    sfr_wr_i <= !rd;
    sfr_rd_i <= rd;
    sfr_addr_i <= a;
    sfr_wdata_i <= d;
    @(posedge clk_i);
    sfr_wr_i <= 1'b0;
    sfr_rd_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    #1;
  endtask

  // Wait for the resume pulse, check its latency, then expect normal mode
  task automatic wait_wake(input int exp_cyc);
    int n;
    for (n = 0; n < 400 && wake_pulse_o !== 1'b1; n++) begin
      @(posedge clk_i);
      #1;
    end
    check(8'(n), 8'(exp_cyc));
    check({7'h00, wake_pulse_o}, 8'h01);
    check_st(st(LPMC_RUN, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1));
    @(posedge clk_i);
    #1;
    check({7'h00, wake_pulse_o}, 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    check_st(st(LPMC_RUN, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1));
    check(sfr_rdata_o, 8'h00);
  endtask

  task automatic t_access();
    sfr(1'b0, PMC_ADDR, 8'h80);
    check({7'h00, baud_double_o}, 8'h01);
    sfr(1'b1, PMC_ADDR, 8'h00);
    check(sfr_rdata_o, PMC_READ_VALUE);
    sfr(1'b0, 8'h86, 8'h03);
    check_st(st(LPMC_RUN, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1));
  endtask

  task automatic t_idle();
    sfr(1'b0, PMC_ADDR, 8'h01);
    check_st(st(LPMC_IDLE, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1));
    sfr(1'b0, PMC_ADDR, 8'h02);
    check_st(st(LPMC_IDLE, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1));
    @(posedge clk_i);
    irq_pending_i <= 1'b1;
    #1;
    wait_wake(IDLE_WAKE_CYC);
    @(posedge clk_i);
    irq_pending_i <= 1'b0;
  endtask

  // Clock enable low: a write is ignored and IDLE holds despite an interrupt
  task automatic t_freeze();
    @(posedge clk_i);
    ce_i <= 1'b0;
    sfr(1'b0, PMC_ADDR, 8'h02);
    check_st(st(LPMC_RUN, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1));
    @(posedge clk_i);
    ce_i <= 1'b1;
    sfr(1'b0, PMC_ADDR, 8'h01);
    check_st(st(LPMC_IDLE, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1));
    @(posedge clk_i);
    ce_i <= 1'b0;
    irq_pending_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    #1;
    check_st(st(LPMC_IDLE, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1));
    @(posedge clk_i);
    ce_i <= 1'b1;
    #1;
    wait_wake(IDLE_WAKE_CYC);
    @(posedge clk_i);
    irq_pending_i <= 1'b0;
  endtask

  task automatic t_stop(input int i);
    @(posedge clk_i);
    cfg <= i[1:0];
    sfr(1'b0, PMC_ADDR, 8'h03);
    check_st(st(LPMC_STOP, 1'b1, 1'b0, 1'b0, cfg[1], cfg[0]));
    @(posedge clk_i);
    irq_pending_i <= 1'b1;
    repeat (6) @(posedge clk_i);
    #1;
    check_st(st(LPMC_STOP, 1'b1, 1'b0, 1'b0, cfg[1], cfg[0]));
    @(posedge clk_i);
    irq_pending_i <= 1'b0;
    src <= 5'h01 << i;
    repeat (2) @(posedge clk_i);
    #1;
    check_st(st(LPMC_OSC_START, 1'b1, 1'b1, 1'b0, cfg[1], cfg[0]));
    wait_wake(OSC_RAMP_CYC + OSC_SETTLE_CYC);
    @(posedge clk_i);
    src <= 5'h00;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Verdict
  task automatic conclude();
    $display("errors=%0d checks=%0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (6) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    #1;
    t_reset();
    t_access();
    t_idle();
    t_freeze();
    for (int i = 0; i < 5; i++) begin
      t_stop(i);
    end
    conclude();
  end

  // Watchdog
  initial begin
    #100000;
    num_errors++;
    conclude();
  end
endmodule
